//--- gss_pkg.sv
package gss_pkg;
   // ----------------------------------------
   // register byte offsets
   // ----------------------------------------
   localparam logic [7:0] OFS_CTRL       = 8'h00;
   localparam logic [7:0] OFS_CRANK_TIME = 8'h04;
   localparam logic [7:0] OFS_CRANK_SPD  = 8'h08;
   localparam logic [7:0] OFS_COOLDOWN   = 8'h0C;
   localparam logic [7:0] OFS_FPT_DELAY  = 8'h10;
   localparam logic [7:0] OFS_PRECRANK   = 8'h14;
   localparam logic [7:0] OFS_EVT_RESP   = 8'h18;
   localparam logic [7:0] OFS_CMD        = 8'h1C;
   localparam logic [7:0] OFS_STATUS     = 8'h20;
   localparam logic [7:0] OFS_EVT_LIMIT  = 8'h24;

   // ----------------------------------------
   // control register fields
   // ----------------------------------------
   localparam int CTRL_AUTO     = 0;
   localparam int CTRL_ECM_STRT = 1;
   localparam int CTRL_OIL_LINK = 2;
   localparam int CTRL_CLT_LINK = 3;
   localparam int CTRL_ESTOP_HI = 4;
   localparam int CTRL_CAN_STOP = 5;
   localparam int CTRL_MODBUS   = 6;
   localparam int CTRL_CYCLE    = 7;
   localparam int CTRL_SEC_LVL  = 8;  // 2 bits, 9:8

   // ----------------------------------------
   // command register bits (write one pulses)
   // ----------------------------------------
   localparam int CMD_RUN_KEY   = 0;
   localparam int CMD_STOP_KEY  = 1;
   localparam int CMD_BYP_OK    = 2;
   localparam int CMD_BYP_ESC   = 3;
   localparam int CMD_RESET_EVT = 4;

   // ----------------------------------------
   // reset values and timing
   // ----------------------------------------
   localparam logic [31:0] RST_CTRL       = 32'h0000_0000;
   localparam logic [31:0] RST_CRANK_TIME = 32'h0000_0100;
   localparam logic [31:0] RST_CRANK_SPD  = 32'h0000_0190;
   localparam logic [31:0] RST_COOLDOWN   = 32'h0000_0100;
   localparam logic [31:0] RST_FPT_DELAY  = 32'h0000_0100;
   localparam logic [31:0] RST_PRECRANK   = 32'h0000_0010;
   localparam logic [31:0] RST_EVT_RESP   = 32'h0000_0000;
   localparam logic [31:0] RST_EVT_LIMIT  = 32'h0000_0040;
   localparam logic [1:0]  SEC_LVL_THREE  = 2'h3;
   localparam int          CLK_MHZ        = 250;
   localparam int          BYPASS_HOLD_S  = 5;
   localparam longint      BYPASS_CYCLES  = longint'(BYPASS_HOLD_S) * CLK_MHZ * 1000000;

   // event responses (two bits each)
   localparam logic [1:0] RESP_OFF  = 2'h0;
   localparam logic [1:0] RESP_WARN = 2'h1;
   localparam logic [1:0] RESP_SOFT = 2'h2;
   localparam logic [1:0] RESP_HARD = 2'h3;

   typedef enum logic [2:0] {
      ST_IDLE, ST_PRECRANK, ST_CRANK, ST_RUNNING, ST_COOLDOWN, ST_STOPPED
   } gss_state_e;
endpackage : gss_pkg

//--- gss_sequencer.sv
// What this block does
// - sensor mode ignores link oil setpoints; idle kept
// - sensor mode ignores link coolant setpoints
// - security level three guards the event limit register
// - starts: run key/switch; auto: remote, modbus, timer
// - refuse crank with present or latched shutdown
// - starter and fuel relays after pre-crank
// - starter until crank time or terminate speed
// - engine module mode: start/fuel sent over can
// - engine module mode skips own crank settings
// - maintained control switch locks out panel run and stop keys
// - remote start held requests run, release stops
// - remote start input is active low
// - stop key, switch stop, or auto sources dropped
// - stop enters cooldown; zero stops at once
// - five second stop hold offers cooldown bypass
// - cooldown end drops fuel, sends can stop
// - sustained excursion or shutdown event stops engine
// - event response setting decides the action
// - soft runs cooldown, hard stops immediately
// - emergency stop polarity is configurable
// - oil/coolant shutdowns masked until fault timer done
module gss_sequencer #(
   parameter longint BYPASS_HOLD = gss_pkg::BYPASS_CYCLES
) (
   // ----------------------------------------
   // clock and reset
   // ----------------------------------------
   input  wire  logic        hclk,
   input  wire  logic        hresetn,
   // ----------------------------------------
   // ahb-lite slave
   // ----------------------------------------
   input  wire  logic        hsel,
   input  wire  logic [31:0] haddr,
   input  wire  logic [1:0]  htrans,
   input  wire  logic        hwrite,
   input  wire  logic [2:0]  hsize,
   input  wire  logic [31:0] hwdata,
   input  wire  logic        hready,
   output logic       [31:0] hrdata,
   output logic              hreadyout,
   output logic              hresp,
   // ----------------------------------------
   // operator and engine inputs
   // ----------------------------------------
   input  wire  logic        ecs_run,
   input  wire  logic        ecs_auto,
   input  wire  logic        ecs_stop,
   input  wire  logic        remote_start_n,
   input  wire  logic        modbus_initiate,
   input  wire  logic        cycle_timer_req,
   input  wire  logic        estop_in,
   input  wire  logic [15:0] engine_speed,
   input  wire  logic [15:0] oil_pres_sensor,
   input  wire  logic [15:0] oil_pres_link,
   input  wire  logic [15:0] oil_pres_idle_lim,
   input  wire  logic        low_idle,
   input  wire  logic [15:0] clt_temp_sensor,
   input  wire  logic [15:0] clt_temp_link,
   input  wire  logic [15:0] oil_limit_sensor,
   input  wire  logic [15:0] oil_limit_link,
   input  wire  logic [15:0] clt_limit_sensor,
   input  wire  logic [15:0] clt_limit_link,
   input  wire  logic        other_shutdown,
   // ----------------------------------------
   // relays and can commands
   // ----------------------------------------
   output logic              starter_relay,
   output logic              fuel_relay,
   output logic              can_start_cmd,
   output logic              can_fuel_cmd,
   output logic              can_stop_cmd,
   output logic              bypass_prompt
);
   if (BYPASS_HOLD < 1 || BYPASS_HOLD > 64'h0000_00FF_FFFF_FFFF) begin : g_bad_hold
      $error("bypass hold must fit the 40 bit hold counter and be at least one");
   end

   // ----------------------------------------
   // bus slave
   // ----------------------------------------
   logic [31:0] ctrl_q, crank_time_q, crank_spd_q, cooldown_q;
   logic [31:0] fpt_delay_q, precrank_q, evt_resp_q, evt_limit_q;
   logic        wr_pend_q;
   logic [7:0]  wr_addr_q;
   logic        rd_pend_q;
   logic [7:0]  rd_addr_q;
   logic [31:0] cmd_pulse;
   logic        sd_latched_q;
   logic        fpt_done_q;
   gss_pkg::gss_state_e state_q;

   wire addr_phase = hsel & hready & htrans[1];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         rd_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
         rd_addr_q <= 8'h00;
      end else begin
         wr_pend_q <= addr_phase & hwrite;
         rd_pend_q <= addr_phase & ~hwrite;
         if (addr_phase) begin
            wr_addr_q <= haddr[7:0];
            rd_addr_q <= haddr[7:0];
         end
      end
   end

   wire wr_en = wr_pend_q;
   // security level three guards the event limit register
   wire sec_ok = ctrl_q[gss_pkg::CTRL_SEC_LVL +: 2] == gss_pkg::SEC_LVL_THREE;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_q       <= gss_pkg::RST_CTRL;
         crank_time_q <= gss_pkg::RST_CRANK_TIME;
         crank_spd_q  <= gss_pkg::RST_CRANK_SPD;
         cooldown_q   <= gss_pkg::RST_COOLDOWN;
         fpt_delay_q  <= gss_pkg::RST_FPT_DELAY;
         precrank_q   <= gss_pkg::RST_PRECRANK;
         evt_resp_q   <= gss_pkg::RST_EVT_RESP;
         evt_limit_q  <= gss_pkg::RST_EVT_LIMIT;
      end else if (wr_en) begin
         case (wr_addr_q)
            gss_pkg::OFS_CTRL:       ctrl_q       <= hwdata;
            gss_pkg::OFS_CRANK_TIME: crank_time_q <= hwdata;
            gss_pkg::OFS_CRANK_SPD:  crank_spd_q  <= hwdata;
            gss_pkg::OFS_COOLDOWN:   cooldown_q   <= hwdata;
            gss_pkg::OFS_FPT_DELAY:  fpt_delay_q  <= hwdata;
            gss_pkg::OFS_PRECRANK:   precrank_q   <= hwdata;
            gss_pkg::OFS_EVT_RESP:   evt_resp_q   <= hwdata;
            gss_pkg::OFS_EVT_LIMIT: begin
               if (sec_ok) evt_limit_q <= hwdata;
            end
            default: ;
         endcase
      end
   end

   assign cmd_pulse = (wr_en && wr_addr_q == gss_pkg::OFS_CMD) ? hwdata : 32'h0000_0000;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata    <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         hrdata    <= 32'h0000_0000;
         if (addr_phase & ~hwrite) begin
            case (haddr[7:0])
               gss_pkg::OFS_CTRL:       hrdata <= ctrl_q;
               gss_pkg::OFS_CRANK_TIME: hrdata <= crank_time_q;
               gss_pkg::OFS_CRANK_SPD:  hrdata <= crank_spd_q;
               gss_pkg::OFS_COOLDOWN:   hrdata <= cooldown_q;
               gss_pkg::OFS_FPT_DELAY:  hrdata <= fpt_delay_q;
               gss_pkg::OFS_PRECRANK:   hrdata <= precrank_q;
               gss_pkg::OFS_EVT_RESP:   hrdata <= evt_resp_q;
               gss_pkg::OFS_EVT_LIMIT:  hrdata <= evt_limit_q;
               gss_pkg::OFS_STATUS: hrdata <= {24'h00_0000, bypass_prompt, fpt_done_q,
                                               sd_latched_q, 2'h0, 3'(state_q)};
               default: hrdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // ----------------------------------------
   // start and stop sources
   // ----------------------------------------
   wire auto_mode  = ctrl_q[gss_pkg::CTRL_AUTO];
   wire ecm_starts = ctrl_q[gss_pkg::CTRL_ECM_STRT];
   // panel run and stop keys ignored while a maintained switch input is active
   wire ecs_held   = ecs_run | ecs_auto | ecs_stop;
   wire run_key    = cmd_pulse[gss_pkg::CMD_RUN_KEY] & ~ecs_held & ~auto_mode;
   wire stop_key   = cmd_pulse[gss_pkg::CMD_STOP_KEY] & ~ecs_held;
   wire remote_on  = ~remote_start_n;
   wire auto_req   = remote_on
                   | (modbus_initiate & ctrl_q[gss_pkg::CTRL_MODBUS])
                   | (cycle_timer_req & ctrl_q[gss_pkg::CTRL_CYCLE]);
   logic        man_run_q;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) man_run_q <= 1'b0;
      else if (stop_key | ecs_stop) man_run_q <= 1'b0;
      else if (run_key) man_run_q <= 1'b1;
   end
   wire run_req  = ecs_run | man_run_q | ((auto_mode | ecs_auto) & auto_req);
   wire stop_req = ecs_stop | stop_key | ~run_req;

   // ----------------------------------------
   // protection: sensor versus data link
   // ----------------------------------------
   wire oil_link = ctrl_q[gss_pkg::CTRL_OIL_LINK];
   wire clt_link = ctrl_q[gss_pkg::CTRL_CLT_LINK];
   wire oil_low  = oil_link ? (oil_pres_link < oil_limit_link)
                            : (oil_pres_sensor < oil_limit_sensor);
   wire idle_low = low_idle & (oil_pres_sensor < oil_pres_idle_lim);
   // coolant limits from the sensor channel only count in sensor mode
   wire clt_high = clt_link ? (clt_temp_link > clt_limit_link)
                            : (clt_temp_sensor > clt_limit_sensor);
   wire estop    = ctrl_q[gss_pkg::CTRL_ESTOP_HI] ? estop_in : ~estop_in;

   logic [31:0] oil_cnt_q, clt_cnt_q;
   // a zero delay must not trip without an excursion present
   wire oil_trip = (oil_low | idle_low) & fpt_done_q & (oil_cnt_q >= evt_limit_q);
   wire clt_trip = clt_high & fpt_done_q & (clt_cnt_q >= evt_limit_q);
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         oil_cnt_q <= 32'h0000_0000;
         clt_cnt_q <= 32'h0000_0000;
      end else begin
         // excursion must persist for the programmed delay
         oil_cnt_q <= ((oil_low | idle_low) & fpt_done_q) ? (oil_trip ? oil_cnt_q : oil_cnt_q + 32'h1)
                                               : 32'h0000_0000;
         clt_cnt_q <= (clt_high & fpt_done_q) ? (clt_trip ? clt_cnt_q : clt_cnt_q + 32'h1)
                                              : 32'h0000_0000;
      end
   end

   wire [1:0] resp_oil = evt_resp_q[1:0];
   wire [1:0] resp_clt = evt_resp_q[3:2];
   wire [1:0] resp_oth = evt_resp_q[5:4];
   function automatic logic is_sd(input logic hit, input logic [1:0] r);
      is_sd = hit & (r == gss_pkg::RESP_SOFT || r == gss_pkg::RESP_HARD);
   endfunction : is_sd
   wire running  = state_q == gss_pkg::ST_RUNNING || state_q == gss_pkg::ST_COOLDOWN;
   wire sd_soft  = running & (is_sd(oil_trip, resp_oil) | is_sd(clt_trip, resp_clt)
                 | is_sd(other_shutdown, resp_oth));
   wire sd_hard  = estop
                 | (running & ((oil_trip & resp_oil == gss_pkg::RESP_HARD)
                 | (clt_trip & resp_clt == gss_pkg::RESP_HARD)
                 | (other_shutdown & resp_oth == gss_pkg::RESP_HARD)));
   wire sd_present = estop | sd_soft | sd_hard;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) sd_latched_q <= 1'b0;
      else if (sd_present) sd_latched_q <= 1'b1;                   // set wins over reset
      else if (cmd_pulse[gss_pkg::CMD_RESET_EVT]) sd_latched_q <= 1'b0;
   end

   // ----------------------------------------
   // stop key hold and bypass prompt
   // ----------------------------------------
   logic [39:0] hold_cnt_q;
   logic        stop_held_q;
   logic        bypass_q;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) stop_held_q <= 1'b0;
      else if (cmd_pulse[gss_pkg::CMD_STOP_KEY] & ~ecs_held) stop_held_q <= hwdata[8]; // bit 8 = key down
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hold_cnt_q    <= 40'h00_0000_0000;
         bypass_prompt <= 1'b0;
         bypass_q      <= 1'b0;
      end else begin
         bypass_q   <= 1'b0;
         hold_cnt_q <= stop_held_q ? hold_cnt_q + 40'h1 : 40'h00_0000_0000;
         if (state_q == gss_pkg::ST_COOLDOWN && stop_held_q && hold_cnt_q >= 40'(BYPASS_HOLD - 1))
            bypass_prompt <= 1'b1;
         if (bypass_prompt && cmd_pulse[gss_pkg::CMD_BYP_OK]) begin
            bypass_prompt <= 1'b0;
            bypass_q      <= 1'b1;
         end else if (bypass_prompt && cmd_pulse[gss_pkg::CMD_BYP_ESC])
            bypass_prompt <= 1'b0;
         else if (state_q != gss_pkg::ST_COOLDOWN)
            bypass_prompt <= 1'b0;
      end
   end

   // ----------------------------------------
   // sequence
   // ----------------------------------------
   logic [31:0] tmr_q;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_q       <= gss_pkg::ST_IDLE;
         tmr_q         <= 32'h0000_0000;
         starter_relay <= 1'b0;
         fuel_relay    <= 1'b0;
         can_start_cmd <= 1'b0;
         can_fuel_cmd  <= 1'b0;
         can_stop_cmd  <= 1'b0;
      end else begin
         can_stop_cmd <= 1'b0;
         tmr_q        <= tmr_q + 32'h1;
         case (state_q)
            gss_pkg::ST_IDLE: begin
               tmr_q <= 32'h0000_0000;
               if (run_req && !stop_req && !sd_present && !sd_latched_q)
                  state_q <= gss_pkg::ST_PRECRANK;
            end
            gss_pkg::ST_PRECRANK: begin
               if (sd_present || stop_req) state_q <= gss_pkg::ST_STOPPED;
               else if (tmr_q >= precrank_q) begin
                  tmr_q   <= 32'h0000_0000;
                  state_q <= gss_pkg::ST_CRANK;
                  if (ecm_starts) begin
                     can_start_cmd <= 1'b1;
                     can_fuel_cmd  <= 1'b1;
                  end else begin
                     starter_relay <= 1'b1;
                     fuel_relay    <= 1'b1;
                  end
               end
            end
            gss_pkg::ST_CRANK: begin
               if (sd_present || stop_req) begin
                  starter_relay <= 1'b0;
                  fuel_relay    <= 1'b0;
                  can_start_cmd <= 1'b0;
                  can_fuel_cmd  <= 1'b0;
                  can_stop_cmd  <= ctrl_q[gss_pkg::CTRL_CAN_STOP];
                  state_q       <= gss_pkg::ST_STOPPED;
               end else if (ecm_starts) begin
                  // the engine module owns crank timing
                  if (engine_speed != 16'h0000) begin
                     can_start_cmd <= 1'b0;
                     tmr_q         <= 32'h0000_0000;
                     state_q       <= gss_pkg::ST_RUNNING;
                  end
               end else if (engine_speed >= crank_spd_q[15:0]) begin
                  starter_relay <= 1'b0;
                  tmr_q         <= 32'h0000_0000;
                  state_q       <= gss_pkg::ST_RUNNING;
               end else if (tmr_q >= crank_time_q) begin
                  starter_relay <= 1'b0;
                  fuel_relay    <= 1'b0;
                  state_q       <= gss_pkg::ST_STOPPED;
               end
            end
            gss_pkg::ST_RUNNING: begin
               if (sd_hard || ((stop_req || sd_soft) && cooldown_q == 32'h0000_0000)) begin
                  fuel_relay    <= 1'b0;
                  can_fuel_cmd  <= 1'b0;
                  can_stop_cmd  <= ctrl_q[gss_pkg::CTRL_CAN_STOP];
                  state_q       <= gss_pkg::ST_STOPPED;
               end else if (sd_soft || stop_req) begin
                  tmr_q   <= 32'h0000_0000;
                  state_q <= gss_pkg::ST_COOLDOWN;
               end
            end
            gss_pkg::ST_COOLDOWN: begin
               if (sd_hard || bypass_q || (tmr_q + 32'h1) >= cooldown_q) begin
                  fuel_relay    <= 1'b0;
                  can_fuel_cmd  <= 1'b0;
                  can_stop_cmd  <= ctrl_q[gss_pkg::CTRL_CAN_STOP];
                  state_q       <= gss_pkg::ST_STOPPED;
               end
            end
            gss_pkg::ST_STOPPED: begin
               if (engine_speed == 16'h0000 && !run_req) state_q <= gss_pkg::ST_IDLE;
            end
            default: state_q <= gss_pkg::ST_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // fault protection timer
   // ----------------------------------------
   logic [31:0] fpt_cnt_q;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fpt_cnt_q  <= 32'h0000_0000;
         fpt_done_q <= 1'b0;
      end else if (!running) begin
         fpt_cnt_q  <= 32'h0000_0000;
         fpt_done_q <= 1'b0;
      end else if (!fpt_done_q) begin
         fpt_cnt_q  <= fpt_cnt_q + 32'h1;
         fpt_done_q <= fpt_cnt_q >= fpt_delay_q;
      end
   end
endmodule : gss_sequencer

//--- gss_sequencer_monitor.sv
module gss_sequencer_monitor #(
   parameter logic [15:0] CRANK_SPD = gss_pkg::RST_CRANK_SPD[15:0]
) (
   // clock, reset, bus answer
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hreadyout,
   input wire logic        hresp,
   // engine side
   input wire logic        estop_in,
   input wire logic [15:0] engine_speed,
   input wire logic        starter_relay,
   input wire logic        fuel_relay,
   input wire logic        can_start_cmd,
   input wire logic        can_fuel_cmd,
   input wire logic        can_stop_cmd
);
   // ------------------------------
   // properties
   // ------------------------------
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // estop polarity is assumed at its reset value, active low
   sequence estop_held;
      !estop_in [*4];
   endsequence
   sequence crank_done;
      starter_relay && engine_speed >= CRANK_SPD;
   endsequence
   ready_okay_a: assert property (hreadyout && !hresp)
      else $error("bus answer not zero wait okay");
   estop_relay_a: assert property (estop_held |-> !fuel_relay && !starter_relay)
      else $error("relays on during estop");
   estop_can_a: assert property (estop_held |-> !can_fuel_cmd && !can_start_cmd)
      else $error("can commands on during estop");
   crank_pair_a: assert property (starter_relay |-> fuel_relay)
      else $error("starter without fuel");
   start_path_a: assert property (!(starter_relay && can_start_cmd))
      else $error("relay and can start together");
   fuel_path_a: assert property (!(fuel_relay && can_fuel_cmd))
      else $error("relay and can fuel together");
   crank_end_a: assert property (crank_done |-> ##[1:2] !starter_relay)
      else $error("starter held past terminate speed");
   stop_pulse_a: assert property (can_stop_cmd |=> !can_stop_cmd)
      else $error("can stop longer than one cycle");
endmodule : gss_sequencer_monitor

bind gss_sequencer gss_sequencer_monitor i_mon (.*);

//--- gss_engine_model.sv
module gss_engine_model (
   // sequencer commands
   input  wire logic        hclk,
   input  wire logic        starter_relay,
   input  wire logic        fuel_relay,
   input  wire logic        can_start_cmd,
   input  wire logic        can_fuel_cmd,
   input  wire logic        slow,
   // measured speed
   output logic      [15:0] engine_speed
);
   timeunit 1ns;
   timeprecision 1ps;
   initial engine_speed = 16'h0000;
   // slow cranking never reaches terminate speed inside the crank time
   always @(posedge hclk) begin
      if ((starter_relay || can_start_cmd) && engine_speed < 16'h0400)
         engine_speed <= engine_speed + (slow ? 16'h0001 : 16'h0008);
      else if (!(fuel_relay || can_fuel_cmd))
         engine_speed <= (engine_speed > 16'h0010) ? engine_speed - 16'h0010 : 16'h0000;
   end
endmodule : gss_engine_model

//--- gss_sequencer_tb.sv
module gss_sequencer_tb;
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------------
   // signals
   // ------------------------------
   logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, slow, low_idle, other_shutdown;
   logic        ecs_run, ecs_auto, ecs_stop, remote_start_n, modbus_initiate, cycle_timer_req, estop_in;
   logic        starter_relay, fuel_relay, can_start_cmd, can_fuel_cmd, can_stop_cmd, bypass_prompt;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [15:0] engine_speed, lim, oil_pres_sensor, clt_temp_sensor;
   logic [31:0] rmodel [11];
   logic [1:0]  resp [3] = '{gss_pkg::RESP_OFF, gss_pkg::RESP_SOFT, gss_pkg::RESP_HARD};
   gss_pkg::gss_state_e ex [3] = '{gss_pkg::ST_RUNNING, gss_pkg::ST_COOLDOWN, gss_pkg::ST_STOPPED};
   int          error_cnt, cmp_count, stop_seen;
   wire  [15:0] oil_pres_link = oil_pres_sensor, clt_temp_link = clt_temp_sensor, oil_pres_idle_lim = lim;
   wire  [15:0] oil_limit_sensor = lim, oil_limit_link = lim, clt_limit_sensor = ~lim, clt_limit_link = ~lim;
   assign hready = hreadyout;
   gss_sequencer #(.BYPASS_HOLD(20)) i_dut (.*);
   gss_engine_model i_eng (.*);
   always @(posedge hclk) if (can_stop_cmd === 1'b1) stop_seen <= 1;
   // ------------------------------
   // tasks
   // ------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      htrans <= 2'h2;
      hwrite <= w;
      haddr  <= {24'h000000, a};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
      if (w && a < 8'h28 && a != gss_pkg::OFS_CMD && a != gss_pkg::OFS_STATUS &&
          (a != gss_pkg::OFS_EVT_LIMIT || rmodel[0][9:8] == gss_pkg::SEC_LVL_THREE))
         rmodel[a[5:2]] = d;
   endtask : bus
   task automatic rd_chk(input logic [7:0] a);
      bus(1'b0, a, 32'h00000000);
      chk(rd, rmodel[a[5:2]]);
   endtask : rd_chk
   task automatic cmd(input logic [31:0] d);
      bus(1'b1, gss_pkg::OFS_CMD, d);
   endtask : cmd
   task automatic to_state(input gss_pkg::gss_state_e s);
      bus(1'b0, gss_pkg::OFS_STATUS, 32'h00000000);
      for (int i = 0; i < 400 && rd[2:0] !== s; i++) bus(1'b0, gss_pkg::OFS_STATUS, 32'h00000000);
      chk({29'h0, rd[2:0]}, {29'h0, s});
   endtask : to_state
   task automatic summarize;
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : summarize
   // ------------------------------
   // sequence
   // ------------------------------
   initial begin
      hclk = 1'b0;
      forever #2 hclk = ~hclk;
   end
   initial begin
      repeat (80000) @(posedge hclk);
      error_cnt++;
      summarize();
   end
   initial begin
      {hresetn, hwrite, ecs_run, ecs_auto, ecs_stop, modbus_initiate, cycle_timer_req} = '0;
      {low_idle, other_shutdown, slow, htrans, haddr, hwdata} = '0;
      {hsel, remote_start_n, estop_in} = '1;
      hsize = 3'h2;
      rmodel = '{gss_pkg::RST_CTRL, gss_pkg::RST_CRANK_TIME, gss_pkg::RST_CRANK_SPD, gss_pkg::RST_COOLDOWN,
                 gss_pkg::RST_FPT_DELAY, gss_pkg::RST_PRECRANK, gss_pkg::RST_EVT_RESP, 32'h0, 32'h0,
                 gss_pkg::RST_EVT_LIMIT, 32'h0};
      void'($urandom(32'h150D15E3));
      lim = 16'($urandom_range(16'h0FFF, 16'h0001));
      oil_pres_sensor = 16'($urandom_range(16'hFFFF, 16'h8000));
      clt_temp_sensor = 16'($urandom_range(16'h0FFF));
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      bus(1'b1, gss_pkg::OFS_EVT_LIMIT, 32'h00000022);
      bus(1'b1, 8'h28, $urandom);
      bus(1'b1, gss_pkg::OFS_FPT_DELAY, $urandom_range(64, 16));
      for (int i = 0; i < 11; i++) if (i != 7 && i != 8) rd_chk(8'(i * 4));
      bus(1'b1, gss_pkg::OFS_CTRL, 32'h00000300);
      bus(1'b1, gss_pkg::OFS_EVT_LIMIT, 32'h00000022);
      rd_chk(gss_pkg::OFS_EVT_LIMIT);
      cmd(32'h00000001);
      to_state(gss_pkg::ST_RUNNING);
      chk({starter_relay, fuel_relay}, 32'h1);
      cmd(32'h00000102);
      to_state(gss_pkg::ST_COOLDOWN);
      repeat (40) @(posedge hclk);
      chk({31'h0, bypass_prompt}, 32'h1);
      cmd(32'h00000004);
      to_state(gss_pkg::ST_STOPPED);
      chk({31'h0, fuel_relay}, 32'h0);
      cmd(32'h00000002);
      to_state(gss_pkg::ST_IDLE);
      slow <= 1'b1;
      cmd(32'h00000001);
      to_state(gss_pkg::ST_STOPPED);
      slow <= 1'b0;
      ecs_stop <= 1'b1;
      to_state(gss_pkg::ST_IDLE);
      ecs_stop <= 1'b0;
      ecs_auto <= 1'b1;
      cmd(32'h00000001);
      repeat (40) @(posedge hclk);
      to_state(gss_pkg::ST_IDLE);
      ecs_auto <= 1'b0;
      bus(1'b1, gss_pkg::OFS_COOLDOWN, 32'h00000000);
      bus(1'b1, gss_pkg::OFS_CTRL, 32'h00000323);
      remote_start_n <= 1'b0;
      to_state(gss_pkg::ST_RUNNING);
      chk({can_fuel_cmd, starter_relay}, 32'h2);
      remote_start_n <= 1'b1;
      to_state(gss_pkg::ST_STOPPED);
      chk(stop_seen, 32'h1);
      to_state(gss_pkg::ST_IDLE);
      bus(1'b1, gss_pkg::OFS_CTRL, 32'h00000301);
      bus(1'b1, gss_pkg::OFS_COOLDOWN, 32'h00000100);
      for (int i = 0; i < 3; i++) begin
         bus(1'b1, gss_pkg::OFS_EVT_RESP, {26'h0, resp[i], 4'h0});
         remote_start_n <= 1'b0;
         to_state(gss_pkg::ST_RUNNING);
         other_shutdown <= 1'b1;
         repeat (20) @(posedge hclk);
         other_shutdown <= 1'b0;
         to_state(ex[i]);
         remote_start_n <= 1'b1;
         cmd(32'h00000010);
         to_state(gss_pkg::ST_IDLE);
      end
      bus(1'b1, gss_pkg::OFS_EVT_RESP, 32'h00000003);
      remote_start_n <= 1'b0;
      to_state(gss_pkg::ST_RUNNING);
      oil_pres_sensor <= 16'h0000;
      to_state(gss_pkg::ST_STOPPED);
      oil_pres_sensor <= 16'hFFFF;
      remote_start_n <= 1'b1;
      cmd(32'h00000010);
      to_state(gss_pkg::ST_IDLE);
      remote_start_n <= 1'b0;
      to_state(gss_pkg::ST_RUNNING);
      estop_in <= 1'b0;
      to_state(gss_pkg::ST_STOPPED);
      repeat (40) @(posedge hclk);
      chk({rd[5], starter_relay}, 32'h2);
      estop_in <= 1'b1;
      remote_start_n <= 1'b1;
      to_state(gss_pkg::ST_IDLE);
      remote_start_n <= 1'b0;
      repeat (40) @(posedge hclk);
      to_state(gss_pkg::ST_IDLE);
      remote_start_n <= 1'b1;
      cmd(32'h00000010);
      to_state(gss_pkg::ST_IDLE);
      bus(1'b1, gss_pkg::OFS_CTRL, 32'h00000310);
      to_state(gss_pkg::ST_IDLE);
      chk({31'h0, rd[5]}, 32'h1);
      summarize();
   end
endmodule : gss_sequencer_tb
